/* File: verilog/wdslp_map.svh */
// Summary of operation
// - Period code 0..11 gives 1:32 doubling to 1:65536
// - Config force bit overrides software enable
// - Sleep entered only by sleep instruction
// - Sleep entry clears counter, keeps it running
// - Sleep entry clears powerdown, sets timeout_n
// - Sleep stops oscillator driver, pins hold state
// - Watchdog reset never drives master clear pin
// - Wake on clear, timeout or enabled interrupt
// - Powerdown flag set at power-up, cleared sleeping
// - Watchdog wake-up clears timeout flag
// - Only clockless interrupt sources may wake
// - Sleep instruction prefetches PC plus one
// - Interrupt wake needs source enable, ignores global
// - Global enable off resumes inline, on vectors 0004h
// - Pending enabled interrupt wakes right after sleep
// - Every wake-up clears watchdog counter
// - Counter counts slow oscillator pulses via prescaler
// - Start-up timer holds watchdog in reset
`ifndef WDSLP_MAP_SVH
`define WDSLP_MAP_SVH
`define WDSLP_OFS_CONTROL      32'h0000_0018
`define WDSLP_OFS_OPTION       32'h0000_0081
`define WDSLP_OFS_CONFIG       32'h0000_2007
`define WDSLP_ADR_CONTROL      32'h0000_0060
`define WDSLP_ADR_OPTION       32'h0000_0204
`define WDSLP_ADR_CONFIG       32'h0000_801C
`define WDSLP_ADR_STATUS       32'h0000_8020
`define WDSLP_RST_CONTROL      8'h08
`define WDSLP_RST_OPTION       8'hFF
`define WDSLP_RST_CONFIG       8'h00
`define WDSLP_BIT_SWEN         0
`define WDSLP_BIT_FORCE        3
`define WDSLP_PS_LSB           1
`define WDSLP_PS_MAX           4'hB
`define WDSLP_BASE_SHIFT       5
`define WDSLP_IRQ_VECTOR       13'h0004
`endif

/* File: verilog/wdslp_pkg.sv */
package wdslp_pkg;
  typedef enum logic [1:0] {
    WDSLP_RUN,
    WDSLP_SLEEP,
    WDSLP_RESUME
  } wdslp_state_type;

  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
  } wdslp_bus_type;

  typedef struct packed {
    logic       sleep;
    logic       clear_watchdog_instr;
    logic [12:0] pc;
  } wdslp_core_type;
endpackage

/* File: verilog/wdslp_counter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdslp_map.svh"
module wdslp_counter #(
  parameter int CNT_W = 21
) (
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Synchronous reset
  input  wire logic       tick,     // Slow oscillator pulse
  input  wire logic       clear,    // Zero the count
  input  wire logic       run,      // Counting allowed
  input  wire logic [3:0] sel,      // Period code
  output logic            expire    // One-cycle expiry pulse
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             exp;
  } wdslp_cnt_type;

  wdslp_cnt_type st_ff;
  wdslp_cnt_type nxt_st;
  logic [CNT_W-1:0] term;

  // Reserved codes clamp to the longest period
  function automatic logic [CNT_W-1:0] period_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > `WDSLP_PS_MAX) ? `WDSLP_PS_MAX : code;
    period_of = CNT_W'(1) << (c + `WDSLP_BASE_SHIFT);
  endfunction

  always_comb
  begin
    term = period_of(sel);
    nxt_st = st_ff;
    nxt_st.exp = 1'b0;
    if (clear || !run)
    begin
      nxt_st.cnt = '0;
    end
    else if (tick)
    begin
      if (st_ff.cnt == term - CNT_W'(1))
      begin
        nxt_st.cnt = '0;
        nxt_st.exp = 1'b1;
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign expire = st_ff.exp;
endmodule
`default_nettype wire

/* File: verilog/wdslp_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdslp_map.svh"
module wdslp_top (
  input  wire logic        SYS_CLK,         // 25 MHz clock
  input  wire logic        RESETN,          // Sync reset, low
  input  wire logic        POWER_ON,        // Power-up reset pulse
  input  wire logic        MASTER_CLEAR_N,  // External clear pin level
  input  wire logic        LFOSC_TICK,      // Slow oscillator pulse
  input  wire logic        OST_ACTIVE,      // Start-up timer busy
  input  wire logic        SLEEP_INSTR,     // Sleep executes, pulse
  input  wire logic        CLEAR_WDT_INSTR, // Clear-watchdog pulse
  input  wire logic [12:0] CORE_PC,         // Address of sleep
  input  wire logic [7:0]  IRQ_FLAGS,       // Clockless source flags
  input  wire logic [7:0]  IRQ_ENABLES,     // Per-source enables
  input  wire logic        GLOBAL_IRQ_ENABLE, // Global enable
  input  wire logic [5:0]  PIN_OUT_IN,      // Core pin levels
  input  wire logic [5:0]  PIN_OE_N_IN,     // Core pin enables, low
  input  wire logic        HSEL,            // AHB select
  input  wire logic [31:0] HADDR,           // AHB address
  input  wire logic [1:0]  HTRANS,          // AHB transfer type
  input  wire logic        HWRITE,          // AHB direction
  input  wire logic [2:0]  HSIZE,           // AHB size
  input  wire logic [31:0] HWDATA,          // AHB write data
  input  wire logic        HREADY,          // AHB ready in
  output logic [31:0]      HRDATA,          // AHB read data
  output logic             HREADYOUT,       // AHB ready out
  output logic             HRESP,           // AHB response
  output logic             CORE_RESET,      // Internal reset pulse
  output logic             CORE_HALT,       // Core stalled in sleep
  output logic             CORE_RESUME,     // Wake, continue pulse
  output logic             CORE_VECTOR,     // Wake, branch after next
  output logic [12:0]      FETCH_ADDR,      // Prefetch address
  output logic             OSC_DRIVE_EN,    // Main oscillator driver
  output logic [5:0]       PIN_OUT,         // Held pin levels
  output logic [5:0]       PIN_OE_N,        // Held pin enables, low
  output logic             MASTER_CLEAR_PIN_OUT,        // Clear pin drive, unused
  output logic             MASTER_CLEAR_PIN_OE_N,       // Clear pin enable, low
  output logic             POWERDOWN_FLAG,  // Status powerdown bit
  output logic             TIMEOUT_FLAG_N   // Status timeout bit
);
  typedef struct packed {
    wdslp_pkg::wdslp_state_type state;
    wdslp_pkg::wdslp_bus_type   bus;
    logic [7:0]  wdctl;
    logic [7:0]  option;
    logic [7:0]  config_w;
    logic        pd;
    logic        to_n;
    logic        core_rst;
    logic        resume;
    logic        vector;
    logic        clr;
    logic [12:0] fetch;
    logic [5:0]  pin_o;
    logic [5:0]  pin_oe_n;
    logic [31:0] rdata;
  } wdslp_top_type;

  wdslp_top_type st_ff;
  wdslp_top_type nxt_st;
  logic          wd_run;
  logic          wd_expire;
  logic          irq_wake;
  logic          wdata_ok;

  // Global enable deliberately not part of the wake term
  assign irq_wake = |(IRQ_FLAGS & IRQ_ENABLES);
  assign wd_run   = (st_ff.config_w[`WDSLP_BIT_FORCE]
                     || st_ff.wdctl[`WDSLP_BIT_SWEN])
                    && !OST_ACTIVE;
  assign wdata_ok = st_ff.bus.req && st_ff.bus.write;

  function automatic logic [31:0] read_mux(input wdslp_top_type s, input logic [31:0] a);
    unique case (a)
      `WDSLP_ADR_CONTROL: read_mux = {24'h00_0000, s.wdctl};
      `WDSLP_ADR_OPTION:  read_mux = {24'h00_0000, s.option};
      `WDSLP_ADR_CONFIG:  read_mux = {24'h00_0000, s.config_w};
      `WDSLP_ADR_STATUS:  read_mux = {30'h0000_0000, s.pd, s.to_n};
      default:            read_mux = 32'h0000_0000;
    endcase
  endfunction

  wdslp_counter #(
    .CNT_W (21)
  ) u_counter (
    .clk    (SYS_CLK),
    .rst_n  (RESETN),
    .tick   (LFOSC_TICK),
    .clear  (st_ff.clr || CLEAR_WDT_INSTR || OST_ACTIVE),
    .run    (wd_run),
    .sel    (st_ff.wdctl[4:1]),
    .expire (wd_expire)
  );

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.core_rst = 1'b0;
    nxt_st.resume   = 1'b0;
    nxt_st.vector   = 1'b0;
    nxt_st.clr      = 1'b0;
    // Register write lands in the data phase
    if (wdata_ok)
    begin
      unique case (st_ff.bus.addr)
        `WDSLP_ADR_CONTROL: nxt_st.wdctl = {3'b000, HWDATA[4:0]};
        `WDSLP_ADR_OPTION:  nxt_st.option = HWDATA[7:0];
        `WDSLP_ADR_CONFIG:  nxt_st.config_w = HWDATA[7:0];
        default:            nxt_st.wdctl = st_ff.wdctl;
      endcase
    end
    nxt_st.bus.req   = HSEL && HREADY && HTRANS[1];
    nxt_st.bus.write = HWRITE;
    nxt_st.bus.addr  = HADDR;
    // Read data held through the data phase, so it stands at the sampling edge
    if (HSEL && HREADY && HTRANS[1] && !HWRITE)
    begin
      nxt_st.rdata = read_mux(st_ff, HADDR);
    end
    if (CLEAR_WDT_INSTR)
    begin
      nxt_st.to_n = 1'b1;
      nxt_st.pd   = 1'b1;
    end
    unique case (st_ff.state)
      wdslp_pkg::WDSLP_RUN:
      begin
        if (SLEEP_INSTR)
        begin
          nxt_st.clr   = 1'b1;
          nxt_st.pd    = 1'b0;
          nxt_st.to_n  = 1'b1;
          nxt_st.fetch = CORE_PC + 13'h0001;
          nxt_st.pin_o    = PIN_OUT_IN;
          nxt_st.pin_oe_n = PIN_OE_N_IN;
          nxt_st.state = wdslp_pkg::WDSLP_SLEEP;
        end
        else if (wd_expire)
        begin
          nxt_st.core_rst = 1'b1;
          nxt_st.to_n     = 1'b0;
        end
      end
      wdslp_pkg::WDSLP_SLEEP:
      begin
        // Pending interrupt at entry wakes in the next cycle
        if (wd_expire)
        begin
          nxt_st.to_n  = 1'b0;
          nxt_st.clr   = 1'b1;
          nxt_st.state = wdslp_pkg::WDSLP_RESUME;
        end
        else if (irq_wake)
        begin
          nxt_st.clr   = 1'b1;
          nxt_st.state = wdslp_pkg::WDSLP_RESUME;
        end
      end
      wdslp_pkg::WDSLP_RESUME:
      begin
        nxt_st.resume = 1'b1;
        nxt_st.vector = GLOBAL_IRQ_ENABLE && irq_wake;
        nxt_st.state  = wdslp_pkg::WDSLP_RUN;
      end
    endcase
    if (!MASTER_CLEAR_N)
    begin
      nxt_st.state    = wdslp_pkg::WDSLP_RUN;
      nxt_st.clr      = 1'b1;
      nxt_st.core_rst = 1'b1;
    end
    if (POWER_ON)
    begin
      nxt_st.pd   = 1'b1;
      nxt_st.to_n = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      st_ff          <= '0;
      st_ff.state    <= wdslp_pkg::WDSLP_RUN;
      st_ff.wdctl    <= `WDSLP_RST_CONTROL;
      st_ff.option   <= `WDSLP_RST_OPTION;
      st_ff.config_w <= `WDSLP_RST_CONFIG;
      st_ff.pd       <= 1'b1;
      st_ff.to_n     <= 1'b1;
      st_ff.pin_oe_n <= 6'h3F;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  wire logic asleep;
  assign asleep = (st_ff.state == wdslp_pkg::WDSLP_SLEEP);

  assign HRDATA         = st_ff.rdata;
  assign HREADYOUT      = 1'b1;
  assign HRESP          = 1'b0;
  assign CORE_RESET     = st_ff.core_rst;
  assign CORE_HALT      = asleep;
  assign CORE_RESUME    = st_ff.resume;
  assign CORE_VECTOR    = st_ff.vector;
  assign FETCH_ADDR     = st_ff.vector ? `WDSLP_IRQ_VECTOR : st_ff.fetch;
  assign OSC_DRIVE_EN   = !asleep;
  assign PIN_OUT        = asleep ? st_ff.pin_o : PIN_OUT_IN;
  assign PIN_OE_N       = asleep ? st_ff.pin_oe_n : PIN_OE_N_IN;
  assign MASTER_CLEAR_PIN_OUT       = 1'b0;
  assign MASTER_CLEAR_PIN_OE_N      = 1'b1;
  assign POWERDOWN_FLAG = st_ff.pd;
  assign TIMEOUT_FLAG_N = st_ff.to_n;
endmodule
`default_nettype wire

/* File: verification/wdslp_top_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module wdslp_top_asserts (
  input wire logic        SYS_CLK,        // Clock
  input wire logic        RESETN,         // Reset, low
  input wire logic        MASTER_CLEAR_N, // Clear pin
  input wire logic        SLEEP_INSTR,    // Sleep pulse
  input wire logic [12:0] CORE_PC,        // Sleep address
  input wire logic        CORE_RESET,     // Reset pulse
  input wire logic        CORE_HALT,      // Asleep
  input wire logic        CORE_RESUME,    // Wake pulse
  input wire logic        CORE_VECTOR,    // Vector pulse
  input wire logic [12:0] FETCH_ADDR,     // Prefetch
  input wire logic        OSC_DRIVE_EN,   // Osc driver
  input wire logic [5:0]  PIN_OUT,        // Pin levels
  input wire logic [5:0]  PIN_OE_N,       // Pin enables
  input wire logic        MASTER_CLEAR_PIN_OUT,       // Clear drive
  input wire logic        MASTER_CLEAR_PIN_OE_N,      // Clear enable
  input wire logic        POWERDOWN_FLAG, // Status bit
  input wire logic        TIMEOUT_FLAG_N  // Status bit
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  property p_no_master_clear_pin; MASTER_CLEAR_PIN_OE_N && !MASTER_CLEAR_PIN_OUT; endproperty
  property p_entry; SLEEP_INSTR && !CORE_HALT && MASTER_CLEAR_N |=>
    CORE_HALT && !POWERDOWN_FLAG && TIMEOUT_FLAG_N; endproperty
  property p_halt_src; $rose(CORE_HALT) |-> $past(SLEEP_INSTR); endproperty
  // Second halt cycle, so a registered driver enable still passes
  property p_osc; CORE_HALT && $past(CORE_HALT) |-> !OSC_DRIVE_EN; endproperty
  property p_pins; CORE_HALT && $past(CORE_HALT) |-> $stable(PIN_OUT) && $stable(PIN_OE_N);
  endproperty
  property p_fetch; SLEEP_INSTR && !CORE_HALT |=> FETCH_ADDR == $past(CORE_PC) + 13'h0001;
  endproperty
  property p_vec; CORE_VECTOR |-> CORE_RESUME && FETCH_ADDR == 13'h0004; endproperty
  // Resume pulse follows one resume-state cycle after the halt
  property p_wake; CORE_RESUME |-> !CORE_RESET && $past(CORE_HALT, 2); endproperty
  a_no_master_clear_pin: assert property (p_no_master_clear_pin) else $error("clear pin driven");
  a_entry: assert property (p_entry) else $error("bad sleep entry");
  a_halt_src: assert property (p_halt_src) else $error("halt without sleep");
  a_osc: assert property (p_osc) else $error("osc on in sleep");
  a_pins: assert property (p_pins) else $error("pins moved in sleep");
  a_fetch: assert property (p_fetch) else $error("bad prefetch");
  a_vec: assert property (p_vec) else $error("bad vector");
  a_wake: assert property (p_wake) else $error("bad wake");
  c_vec: cover property (CORE_VECTOR);
  c_wdt_wake: cover property (CORE_RESUME && !TIMEOUT_FLAG_N);
  c_reset: cover property (CORE_RESET && !CORE_HALT);
endmodule
bind wdslp_top wdslp_top_asserts u_chk (.*);
`default_nettype wire

/* File: verification/wdslp_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "wdslp_map.svh"
module wdslp_top_bench;
  logic SYS_CLK, RESETN, POWER_ON, MASTER_CLEAR_N, LFOSC_TICK, OST_ACTIVE, SLEEP_INSTR;
  logic CLEAR_WDT_INSTR, GLOBAL_IRQ_ENABLE, HSEL, HWRITE, HREADYOUT, HRESP, CORE_RESET;
  logic CORE_HALT, CORE_RESUME, CORE_VECTOR, OSC_DRIVE_EN, MASTER_CLEAR_PIN_OUT, MASTER_CLEAR_PIN_OE_N;
  logic POWERDOWN_FLAG, TIMEOUT_FLAG_N;
  logic [12:0] CORE_PC, FETCH_ADDR;
  logic [7:0]  IRQ_FLAGS, IRQ_ENABLES;
  logic [5:0]  PIN_OUT_IN, PIN_OE_N_IN, PIN_OUT, PIN_OE_N;
  logic [31:0] HADDR, HWDATA, HRDATA, rd, rng;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  wire         HREADY = HREADYOUT;
  int          miscompares, samples_checked, c, p[3];
  logic        rst_q, rsm_q, vec_q, halt_q;
  logic [12:0] fa_q;
  wdslp_top uut (.*);
  // Outputs captured mid-cycle, read at the next rising edge without a race
  always @(negedge SYS_CLK)
  begin
    rst_q <= CORE_RESET;
    rsm_q <= CORE_RESUME;
    vec_q <= CORE_VECTOR;
    halt_q <= CORE_HALT;
    fa_q <= FETCH_ADDR;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic rdy;
    @(posedge SYS_CLK);
    for (int n = 0; HREADYOUT !== 1'b1; n++)
    begin
      if (n == 50)
      begin
        miscompares++;
        tally_and_finish();
      end
      @(posedge SYS_CLK);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    rdy();
    HTRANS <= 2'b00;
    HWDATA <= d;
    rdy();
    rd = HRDATA;
  endtask
  // Returns -1 when the pulse never shows within the bound
  task automatic waitf(input int lim, input bit rsm, output int n);
    n = 0;
    @(posedge SYS_CLK);
    while ((rsm ? rsm_q : rst_q) !== 1'b1 && n < lim)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n == lim)
      n = -1;
  endtask
  task automatic slp;
    logic [12:0] pc;
    pc = rng[24:12];
    SLEEP_INSTR <= 1'b1;
    CORE_PC <= pc;
    @(posedge SYS_CLK);
    SLEEP_INSTR <= 1'b0;
    @(posedge SYS_CLK);
    chk(halt_q, 1);
    chk(fa_q, 13'(pc + 13'h0001));
  endtask
  initial
  begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // Random pin traffic keeps the sleep hold honest
  always @(posedge SYS_CLK)
  begin
    rng = xs(rng);
    PIN_OUT_IN <= rng[5:0];
    PIN_OE_N_IN <= rng[11:6];
  end
  initial
  begin
    {RESETN, POWER_ON, SLEEP_INSTR, CLEAR_WDT_INSTR, OST_ACTIVE, GLOBAL_IRQ_ENABLE} = '0;
    {HTRANS, HADDR, HWRITE, HWDATA, CORE_PC, IRQ_FLAGS, IRQ_ENABLES} = '0;
    {MASTER_CLEAR_N, LFOSC_TICK, HSEL} = 3'h7;
    {PIN_OUT_IN, PIN_OE_N_IN} = '0;
    HSIZE = 3'h2;
    rng = 32'h0000_3f64;
    repeat (10) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    bus(0, `WDSLP_ADR_CONTROL, 0); chk(rd, 32'h0000_0008);
    bus(0, `WDSLP_ADR_STATUS, 0); chk(rd, 3);
    bus(1, `WDSLP_ADR_CONTROL, 32'h0000_00FE);
    bus(0, `WDSLP_ADR_CONTROL, 0); chk(rd, 32'h0000_001E);
    bus(0, 32'h0000_0100, 0); chk(rd, 0);
    $display("test 1 done");
    for (int k = 0; k < 3; k++)
    begin
      bus(1, `WDSLP_ADR_CONTROL, (k << 1) | 1);
      waitf(300, 0, c);
      waitf(300, 0, p[k]);
    end
    chk(p[1] - p[0], 32);
    chk(p[2] - p[1], 64);
    bus(0, `WDSLP_ADR_STATUS, 0); chk(rd, 2);
    $display("test 2 done");
    bus(1, `WDSLP_ADR_CONTROL, 0);
    bus(1, `WDSLP_ADR_CONFIG, 8);
    waitf(300, 0, c); chk(c >= 0, 1);
    bus(1, `WDSLP_ADR_CONFIG, 0);
    waitf(300, 0, c); chk(c, -1);
    $display("test 3 done");
    POWER_ON <= 1'b1;
    @(posedge SYS_CLK);
    POWER_ON <= 1'b0;
    bus(0, `WDSLP_ADR_STATUS, 0); chk(rd, 3);
    for (int g = 0; g < 2; g++)
    begin
      GLOBAL_IRQ_ENABLE <= g[0];
      IRQ_FLAGS <= 8'h08;
      IRQ_ENABLES <= g ? 8'h00 : 8'h08;
      slp();
      if (g)
      begin
        waitf(20, 1, c); chk(c, -1);
        IRQ_ENABLES <= 8'h08;
      end
      waitf(20, 1, c); chk(c >= 0, 1);
      chk(vec_q, g);
      if (g)
        chk(fa_q, 4);
      {IRQ_FLAGS, IRQ_ENABLES} <= '0;
      bus(0, `WDSLP_ADR_STATUS, 0); chk(rd, 1);
    end
    $display("test 4 done");
    bus(1, `WDSLP_ADR_CONTROL, 1);
    slp();
    waitf(100, 1, c); chk(c >= 0, 1);
    chk(rst_q, 0);
    bus(0, `WDSLP_ADR_STATUS, 0); chk(rd, 0);
    bus(1, `WDSLP_ADR_CONTROL, 0);
    $display("test 5 done");
    slp();
    MASTER_CLEAR_N <= 1'b0;
    @(posedge SYS_CLK);
    MASTER_CLEAR_N <= 1'b1;
    waitf(10, 0, c); chk(c >= 0, 1);
    chk(halt_q, 0);
    $display("test 6 done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
